// File: hw/mc_pkg.sv
package busmem_pkg;
    // register byte offsets on the control bus
    localparam logic [7:0] OFF_REMAP = 8'h00;
    localparam logic [7:0] OFF_ABORT_STATUS = 8'h04;
    localparam logic [7:0] OFF_ABORT_ADDRESS = 8'h08;
    // field positions
    localparam int REMAP_TOGGLE_BIT = 0;
    localparam int UNDEF_BIT = 0;
    localparam int MISALIGN_BIT = 1;
    localparam int SIZE_LSB = 8;
    localparam int TYPE_LSB = 10;
    localparam int LAST_LSB = 16;
    localparam int STICKY_LSB = 24;
    // access size and type encodings
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] TYPE_READ = 2'h0;
    localparam logic [1:0] TYPE_WRITE = 2'h1;
    localparam logic [1:0] TYPE_FETCH = 2'h2;
    // address map
    localparam logic [3:0] REGION_MEMORY = 4'h0;
    localparam logic [3:0] REGION_PERIPH = 4'hf;
    localparam logic [7:0] SLOT_ZERO = 8'h00;
    localparam logic [7:0] SLOT_FLASH = 8'h01;
    localparam logic [7:0] SLOT_SRAM = 8'h02;
    localparam int SLOT_BITS = 20;
    // master indices, highest priority first
    localparam int M_ETH = 0;
    localparam int M_DMA = 1;
    localparam int M_CPU = 2;
    localparam int N_MASTERS = 3;
    // slave select indices
    localparam int SEL_FLASH = 0;
    localparam int SEL_SRAM = 1;
    localparam int SEL_PERIPH = 2;
    // reset values
    localparam logic [31:0] RESET_WORD = 32'h0;
    localparam logic RESET_REMAP = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_XFER = 3'b010,
        ST_DONE = 3'b100
    } state_t;
endpackage

// File: hw/bus_memory_controller.sv
`timescale 1ns/1ps
// Overview of operation
// - three masters, fixed priority: ethernet, then dma, then cpu
// - little-endian only; byte lanes pass straight through, no swapping
// - top address nibble picks one of sixteen 256-Mbyte regions
// - access to any of the fourteen undefined regions is aborted
// - memory region: eight more bits give each memory a 1-Mbyte slot
// - smaller memories repeat across their slot by address wrapping
// - access to an unallocated memory slot is aborted
// - area zero holds flash before remap, sram after remap
// - memory in area zero also stays reachable at its own slot
// - each written one to the remap toggle bit, with byte lane 0 enabled, flips the mapping
// - abort indication goes to every master at once
// - full 32-bit address of each aborted access is captured
// - abort records size, type, undefined or misaligned cause
// - one last-source flag per master for the latest abort
// - sticky per-master flags for aborts not shown in last-source
// - word needs address bits 1:0 zero, halfword needs bit 0 zero
// - misaligned access is cancelled and aborted
// - cpu instruction fetches skip the alignment check
// - size field: byte 00, halfword 01, word 10
// - type field: read 00, write 01, fetch 10
// - writing zero to the remap toggle bit changes nothing
module bus_memory_controller #(
    parameter int FLASH_AW = 16,
    parameter int SRAM_AW = 14
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic eth_req,
    input wire logic [31:0] eth_addr,
    input wire logic eth_write,
    input wire logic [1:0] eth_size,
    input wire logic [31:0] eth_wdata,
    input wire logic dma_req,
    input wire logic [31:0] dma_addr,
    input wire logic dma_write,
    input wire logic [1:0] dma_size,
    input wire logic [31:0] dma_wdata,
    input wire logic cpu_req,
    input wire logic [31:0] cpu_addr,
    input wire logic cpu_write,
    input wire logic [1:0] cpu_size,
    input wire logic cpu_fetch,
    input wire logic [31:0] cpu_wdata,
    output logic [busmem_pkg::N_MASTERS-1:0] master_grant,
    output logic [busmem_pkg::N_MASTERS-1:0] master_done,
    output logic bus_abort,
    output logic [31:0] master_rdata,
    output logic [2:0] slave_sel,
    output logic [31:0] slave_addr,
    output logic slave_write,
    output logic [1:0] slave_size,
    output logic [31:0] slave_wdata,
    input wire logic slave_ready,
    input wire logic [31:0] slave_rdata,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import busmem_pkg::*;

    if (FLASH_AW < 2 || FLASH_AW > SLOT_BITS) begin : g_bad_flash
        $error("FLASH_AW must lie between 2 and 20");
    end
    if (SRAM_AW < 2 || SRAM_AW > SLOT_BITS) begin : g_bad_sram
        $error("SRAM_AW must lie between 2 and 20");
    end

    localparam logic [19:0] FLASH_MASK = 20'((64'h1 << FLASH_AW) - 1);
    localparam logic [19:0] SRAM_MASK = 20'((64'h1 << SRAM_AW) - 1);

    typedef struct packed {
        state_t state;
        logic [2:0] owner;
        logic [2:0] done;
        logic abort;
        logic [31:0] rdata;
        logic [2:0] sel;
        logic [31:0] s_addr;
        logic s_write;
        logic [1:0] s_size;
        logic [31:0] s_wdata;
        logic remap;
        logic undef;
        logic misal;
        logic [1:0] a_size;
        logic [1:0] a_type;
        logic [2:0] last;
        logic last_unread;
        logic [2:0] sticky;
        logic [31:0] a_addr;
        logic wait_req;
        logic [31:0] rd;
    } regs_t;

    regs_t r;
    regs_t next_r;

    logic [2:0] req;
    logic [2:0][31:0] addr_m;
    logic [2:0] write_m;
    logic [2:0][1:0] size_m;
    logic [2:0][31:0] wdata_m;

    assign req = {cpu_req, dma_req, eth_req};
    assign addr_m = {cpu_addr, dma_addr, eth_addr};
    assign write_m = {cpu_write, dma_write, eth_write};
    assign size_m = {cpu_size, dma_size, eth_size};
    assign wdata_m = {cpu_wdata, dma_wdata, eth_wdata};

    // selected request and its decode
    logic [2:0] pick;
    logic [31:0] a;
    logic wr;
    logic [1:0] sz;
    logic fetch;
    logic undef;
    logic misal;
    logic [2:0] sel;
    logic [31:0] out_addr;
    logic acc;
    logic [31:0] status_word;

    always_comb begin
        pick = 3'h0;
        if (req[M_ETH]) begin
            pick[M_ETH] = 1'b1;
        end else if (req[M_DMA]) begin
            pick[M_DMA] = 1'b1;
        end else if (req[M_CPU]) begin
            pick[M_CPU] = 1'b1;
        end
        a = 32'h0;
        wr = 1'b0;
        sz = SIZE_BYTE;
        for (int i = 0; i < N_MASTERS; i++) begin
            if (pick[i]) begin
                a = addr_m[i];
                wr = write_m[i];
                sz = size_m[i];
            end
        end
        // only the cpu fetches instructions
        fetch = pick[M_CPU] & cpu_fetch;
    end

    always_comb begin
        sel = 3'h0;
        out_addr = a;
        undef = 1'b1;
        // region decode on the top nibble
        if (a[31:28] == REGION_PERIPH) begin
            sel[SEL_PERIPH] = 1'b1;
            undef = 1'b0;
        end else if (a[31:28] == REGION_MEMORY) begin
            // slot decode on the next eight bits
            case (a[27:20])
                SLOT_ZERO: begin
                    // area zero follows the remap state
                    undef = 1'b0;
                    if (r.remap) begin
                        sel[SEL_SRAM] = 1'b1;
                    end else begin
                        sel[SEL_FLASH] = 1'b1;
                    end
                end
                SLOT_FLASH: begin
                    undef = 1'b0;
                    sel[SEL_FLASH] = 1'b1;
                end
                SLOT_SRAM: begin
                    undef = 1'b0;
                    sel[SEL_SRAM] = 1'b1;
                end
                default: begin
                    undef = 1'b1;
                end
            endcase
            // wrap within memory size, so copies repeat
            if (sel[SEL_FLASH]) begin
                out_addr = {12'h0, a[19:0] & FLASH_MASK};
            end else begin
                out_addr = {12'h0, a[19:0] & SRAM_MASK};
            end
        end
        // other fourteen regions leave undef set
        misal = 1'b0;
        if (sz == SIZE_WORD) begin
            misal = (a[1:0] != 2'h0);
        end else if (sz == SIZE_HALF) begin
            misal = a[0];
        end
        if (fetch) begin
            misal = 1'b0;
        end
    end

    // register bus accept edge: request seen with waitrequest low
    assign acc = (avs_read | avs_write) & ~r.wait_req;

    always_comb begin
        status_word = 32'h0;
        status_word[UNDEF_BIT] = r.undef;
        status_word[MISALIGN_BIT] = r.misal;
        status_word[SIZE_LSB +: 2] = r.a_size;
        status_word[TYPE_LSB +: 2] = r.a_type;
        status_word[LAST_LSB +: 3] = r.last;
        status_word[STICKY_LSB +: 3] = r.sticky;
    end

    always_comb begin
        next_r = r;
        next_r.done = 3'h0;
        next_r.abort = 1'b0;
        case (r.state)
            ST_IDLE: begin
                // arbitrate only while no transfer is open
                if (pick != 3'h0) begin
                    next_r.owner = pick;
                    if (undef || misal) begin
                        next_r.state = ST_DONE;
                        next_r.done = pick;
                        // one abort line shared by all masters
                        next_r.abort = 1'b1;
                        next_r.a_addr = a;
                        next_r.undef = undef;
                        next_r.misal = misal;
                        next_r.a_size = sz;
                        // type code from direction and fetch
                        if (fetch) begin
                            next_r.a_type = TYPE_FETCH;
                        end else if (wr) begin
                            next_r.a_type = TYPE_WRITE;
                        end else begin
                            next_r.a_type = TYPE_READ;
                        end
                        // newest abort source replaces the last
                        next_r.last = pick;
                        next_r.last_unread = 1'b1;
                    end else begin
                        next_r.state = ST_XFER;
                        next_r.sel = sel;
                        next_r.s_addr = out_addr;
                        next_r.s_write = wr;
                        next_r.s_size = sz;
                        next_r.s_wdata = wdata_m[0];
                        for (int i = 0; i < N_MASTERS; i++) begin
                            if (pick[i]) begin
                                next_r.s_wdata = wdata_m[i];
                            end
                        end
                    end
                end
            end
            ST_XFER: begin
                // grant held until the slave completes
                if (slave_ready) begin
                    next_r.state = ST_DONE;
                    next_r.sel = 3'h0;
                    next_r.s_write = 1'b0;
                    next_r.rdata = slave_rdata;
                    next_r.done = r.owner;
                end
            end
            ST_DONE: begin
                // gap cycle lets the master drop its request
                next_r.state = ST_IDLE;
                next_r.owner = 3'h0;
            end
            default: begin
                next_r.state = ST_IDLE;
                next_r.owner = 3'h0;
                next_r.sel = 3'h0;
            end
        endcase

        // sticky: set by abort, cleared by status read
        // an abort on the edge that accepts a status read stays unread,
        // and an unread earlier last source moves into sticky
        if (acc && avs_read && avs_address == OFF_ABORT_STATUS) begin
            next_r.sticky = 3'h0;
            next_r.last_unread = 1'b0;
        end
        if (next_r.abort) begin
            // set wins over a clear in the same cycle
            next_r.sticky = next_r.sticky
                | (r.sticky & {3{~acc}})
                | (r.last & {3{r.last_unread}});
            next_r.last_unread = 1'b1;
        end

        // register bus: one wait cycle, then answer for one cycle
        if (avs_read || avs_write) begin
            next_r.wait_req = ~r.wait_req;
        end else begin
            next_r.wait_req = 1'b1;
        end
        if ((avs_read || avs_write) && r.wait_req) begin
            case (avs_address)
                OFF_ABORT_STATUS: next_r.rd = status_word;
                OFF_ABORT_ADDRESS: next_r.rd = r.a_addr;
                default: next_r.rd = 32'h0;
            endcase
        end
        // a written one with byte lane 0 enabled toggles the mapping
        // a written zero leaves it alone
        if (acc && avs_write && avs_address == OFF_REMAP
            && avs_byteenable[0] && avs_writedata[REMAP_TOGGLE_BIT]) begin
            next_r.remap = ~r.remap;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            // reset clears capture state and mapping
            r.state <= ST_IDLE;
            r.owner <= 3'h0;
            r.done <= 3'h0;
            r.abort <= 1'b0;
            r.rdata <= RESET_WORD;
            r.sel <= 3'h0;
            r.s_addr <= RESET_WORD;
            r.s_write <= 1'b0;
            r.s_size <= SIZE_BYTE;
            r.s_wdata <= RESET_WORD;
            r.remap <= RESET_REMAP;
            r.undef <= 1'b0;
            r.misal <= 1'b0;
            r.a_size <= SIZE_BYTE;
            r.a_type <= TYPE_READ;
            r.last <= 3'h0;
            r.last_unread <= 1'b0;
            r.sticky <= 3'h0;
            r.a_addr <= RESET_WORD;
            r.wait_req <= 1'b1;
            r.rd <= RESET_WORD;
        end else begin
            r <= next_r;
        end
    end

    // dma and ethernet masters may leave bus_abort unused
    assign master_grant = r.owner;
    assign master_done = r.done;
    assign bus_abort = r.abort;
    assign master_rdata = r.rdata;
    assign slave_sel = r.sel;
    assign slave_addr = r.s_addr;
    assign slave_write = r.s_write;
    assign slave_size = r.s_size;
    assign slave_wdata = r.s_wdata;
    assign avs_readdata = r.rd;
    assign avs_waitrequest = r.wait_req;
endmodule // bus_memory_controller

// File: sim/bus_memory_controller_properties.sv
`timescale 1ns/1ps
module busmem_checker
    import busmem_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic eth_req,
    input wire logic dma_req,
    input wire logic [31:0] cpu_addr,
    input wire logic [1:0] cpu_size,
    input wire logic cpu_fetch,
    input wire logic [busmem_pkg::N_MASTERS-1:0] master_grant,
    input wire logic [busmem_pkg::N_MASTERS-1:0] master_done,
    input wire logic bus_abort,
    input wire logic [2:0] slave_sel,
    input wire logic slave_ready,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic cpu_go, undef, misal;
    // only the cpu is decoded here, to keep the port list short
    assign cpu_go = master_grant[M_CPU];
    assign undef = (cpu_addr[31:28] != REGION_MEMORY &&
        cpu_addr[31:28] != REGION_PERIPH) ||
        (cpu_addr[31:28] == REGION_MEMORY && cpu_addr[27:20] > SLOT_SRAM);
    assign misal = !cpu_fetch && ((cpu_size == SIZE_WORD &&
        cpu_addr[1:0] != 2'h0) || (cpu_size == SIZE_HALF && cpu_addr[0]));
    sequence s_cpu_start;
        $rose(cpu_go);
    endsequence
    sequence s_slave_end;
        slave_sel != 3'h0 && slave_ready;
    endsequence
    a_grant_onehot: assert property ($onehot0(master_grant))
        else $error("more than one grant");
    a_dma_yields: assert property ($rose(master_grant[M_DMA]) |->
        !$past(eth_req)) else $error("dma granted over ethernet");
    a_cpu_last: assert property (s_cpu_start |->
        !$past(eth_req) && !$past(dma_req)) else $error("cpu granted early");
    a_grant_held: assert property (master_grant != 3'h0 &&
        master_done == 3'h0 |=> $stable(master_grant))
        else $error("grant moved mid transfer");
    a_abort_all: assert property (bus_abort |->
        master_done != 3'h0 && slave_sel == 3'h0)
        else $error("abort without done");
    a_done_owner: assert property (master_done != 3'h0 |->
        master_done == master_grant) else $error("done not to owner");
    a_undef_abort: assert property ((s_cpu_start ##0 undef) |->
        bus_abort) else $error("undefined access not aborted");
    a_misalign_abort: assert property ((s_cpu_start ##0 misal) |->
        bus_abort) else $error("misaligned access not aborted");
    a_aligned_goes: assert property ((s_cpu_start ##0 !misal &&
        !undef) |-> !bus_abort && slave_sel != 3'h0)
        else $error("legal access refused");
    a_slave_done: assert property (s_slave_end |=>
        master_done != 3'h0 && slave_sel == 3'h0)
        else $error("no done after slave ready");
    a_reg_answer: assert property ($rose(avs_read || avs_write) |=>
        !avs_waitrequest ##1 avs_waitrequest)
        else $error("register answer late");
endmodule // busmem_checker

bind bus_memory_controller busmem_checker chk (.mclk, .rstn, .eth_req,
    .dma_req, .cpu_addr, .cpu_size, .cpu_fetch, .master_grant,
    .master_done, .bus_abort, .slave_sel, .slave_ready, .avs_read,
    .avs_write, .avs_waitrequest);

// File: sim/slave_model.sv
`timescale 1ns/1ps
module slave_model (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [2:0] slave_sel,
    input wire logic [31:0] slave_addr,
    output logic slave_ready,
    output logic [31:0] slave_rdata
);
    logic [1:0] wait_cnt;
    logic [31:0] pat;
    assign pat = slave_addr ^ {slave_sel, 29'h0};
    // inverted when not ready so stale data never matches
    assign slave_rdata = slave_ready ? pat : ~pat;
    always @(posedge mclk) begin
        if (!rstn || slave_sel == 3'h0) begin
            slave_ready <= 1'b0;
            wait_cnt <= 2'($urandom % 3);
        end else if (slave_ready) begin
            slave_ready <= 1'b0;
        end else if (wait_cnt == 2'h0) begin
            slave_ready <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt - 2'h1;
        end
    end
endmodule // slave_model

// File: sim/bus_memory_controller_tb.sv
`timescale 1ns/1ps
module bus_memory_controller_tb;
    import busmem_pkg::*;
    logic mclk, rstn, cpu_fetch, bus_abort, slave_ready, remap, slave_write;
    logic [1:0] slave_size;
    logic [3:0] avs_be;
    logic avs_read, avs_write, avs_wait;
    logic [2:0] req, wr, grant, done, slave_sel;
    logic [1:0] size [3];
    logic [31:0] addr [3], wdata [3];
    logic [31:0] rdata, slave_addr, slave_rdata, avs_wdata, avs_rdata;
    logic [31:0] slave_wdata;
    logic [7:0] avs_addr;
    logic [33:0] exp_bus [3][$];
    logic [69:0] exp_slv [3][$];
    logic [31:0] exp_reg [$];
    int err_count, checked, cycles;
    int seen [$];
    logic [31:0] ta [11] = '{32'h0000_0000, 32'h0010_0004, 32'h0020_0008,
        32'hf000_0000, 32'h3000_0000, 32'h0030_0000, 32'h0010_0002,
        32'h0020_0001, 32'h0010_0003, 32'h0020_0003, 32'h5000_0000};
    logic [1:0] ts [11] = '{2'h2, 2'h1, 2'h2, 2'h0, 2'h0, 2'h1, 2'h2,
        2'h1, 2'h2, 2'h0, 2'h2};
    logic [10:0] tf = 11'h500, tu = 11'h430, tm = 11'h0c0;
    logic [31:0] rw [4] = '{32'h1, 32'hfffe, 32'h1, 32'h1};
    logic [3:0] rb [4] = '{4'hf, 4'hf, 4'he, 4'hf};

    bus_memory_controller uut (.mclk(mclk), .rstn(rstn),
        .eth_req(req[0]), .eth_addr(addr[0]), .eth_write(wr[0]),
        .eth_size(size[0]), .eth_wdata(wdata[0]),
        .dma_req(req[1]), .dma_addr(addr[1]), .dma_write(wr[1]),
        .dma_size(size[1]), .dma_wdata(wdata[1]),
        .cpu_req(req[2]), .cpu_addr(addr[2]), .cpu_write(wr[2]),
        .cpu_size(size[2]), .cpu_fetch(cpu_fetch), .cpu_wdata(wdata[2]),
        .master_grant(grant), .master_done(done), .bus_abort(bus_abort),
        .master_rdata(rdata), .slave_sel(slave_sel),
        .slave_addr(slave_addr), .slave_write(slave_write),
        .slave_size(slave_size), .slave_wdata(slave_wdata),
        .slave_ready(slave_ready),
        .slave_rdata(slave_rdata), .avs_address(avs_addr),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_wdata), .avs_byteenable(avs_be),
        .avs_readdata(avs_rdata), .avs_waitrequest(avs_wait));
    slave_model far (.mclk(mclk), .rstn(rstn), .slave_sel(slave_sel),
        .slave_addr(slave_addr), .slave_ready(slave_ready),
        .slave_rdata(slave_rdata));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmp(string what, logic [33:0] e, logic [33:0] s);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask
    function automatic logic [2:0] exp_sel(logic [31:0] a);
        if (a[31:28] == REGION_PERIPH) return 3'b100;
        if (a[27:20] == SLOT_SRAM || (a[27:20] == SLOT_ZERO && remap))
            return 3'b010;
        return 3'b001;
    endfunction
    function automatic logic [31:0] exp_sa(logic [31:0] a);
        if (a[31:28] == REGION_PERIPH) return a;
        if (exp_sel(a) == 3'b010) return {18'h0, a[13:0]};
        return {16'h0, a[15:0]};
    endfunction
    function automatic logic [31:0] exp_rd(logic [31:0] a);
        if (a[31:28] == REGION_PERIPH) return a ^ 32'h8000_0000;
        if (a[27:20] == SLOT_SRAM || (a[27:20] == SLOT_ZERO && remap))
            return {18'h0, a[13:0]} ^ 32'h4000_0000;
        return {16'h0, a[15:0]} ^ 32'h2000_0000;
    endfunction
    function automatic logic [31:0] st(logic u, mi, logic [1:0] sz, tp,
            logic [2:0] last, sv);
        st = 32'h0;
        st[UNDEF_BIT] = u;
        st[MISALIGN_BIT] = mi;
        st[SIZE_LSB+:2] = sz;
        st[TYPE_LSB+:2] = tp;
        st[LAST_LSB+:3] = last;
        st[STICKY_LSB+:3] = sv;
    endfunction
    // master request held until its done bit is seen
    task automatic xfer(int m, logic [31:0] a, logic w, logic [1:0] sz,
            logic f, logic ab);
        int n = 0;
        logic [31:0] d = $urandom;
        exp_bus[m].push_back({!w && !ab, ab, (w || ab) ? 32'h0 : exp_rd(a)});
        if (!ab) exp_slv[m].push_back({exp_sel(a), w, sz, d, exp_sa(a)});
        addr[m] <= a;
        wr[m] <= w;
        size[m] <= sz;
        wdata[m] <= d;
        if (m == M_CPU) cpu_fetch <= f;
        req[m] <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (done[m] !== 1'b1 && n < 50);
        if (n == 50) cmp("done wait", 34'h1, 34'h0);
        req[m] <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic reg_acc(logic w, logic [7:0] a, logic [31:0] d,
            logic [3:0] be);
        int n = 0;
        avs_addr <= a;
        avs_wdata <= d;
        avs_be <= be;
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_wait !== 1'b0 && n < 50);
        if (n == 50) cmp("reg wait", 34'h1, 34'h0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        exp_reg.push_back(e);
        reg_acc(1'b0, a, 32'h0, 4'hf);
    endtask

    always @(posedge mclk) begin
        logic [33:0] eb;
        logic [69:0] es;
        for (int m = 0; m < 3; m++) begin
            if (done[m] === 1'b1) begin
                seen.push_back(m);
                if (exp_bus[m].size() == 0) cmp("extra done", 34'h1, 34'h0);
                else begin
                    eb = exp_bus[m].pop_front();
                    cmp("bus", eb, {eb[33], bus_abort,
                        eb[33] ? rdata : 32'h0});
                end
            end
            if (grant[m] === 1'b1 && slave_sel !== 3'h0
                    && slave_ready === 1'b1) begin
                es = exp_slv[m].size() ? exp_slv[m].pop_front() : '1;
                cmp("slave addr", {2'h0, es[31:0]},
                    {2'h0, slave_addr});
                cmp("slave wdata", {2'h0, es[63:32]},
                    {2'h0, slave_wdata});
                cmp("slave ctl", {28'h0, es[69:64]},
                    {28'h0, slave_sel, slave_write, slave_size});
            end
        end
        if (avs_read && avs_wait === 1'b0)
            cmp("reg", exp_reg.pop_front(), avs_rdata);
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            finish_test();
        end
    end

    initial begin
        logic [31:0] a;
        logic w;
        void'($urandom(32'hb3ff));
        {rstn, req, wr, cpu_fetch, avs_read, avs_write, remap} = '0;
        size = '{default: 2'h0};
        addr = '{default: 32'h0};
        wdata = '{default: 32'h0};
        avs_addr = 8'h0;
        avs_wdata = 32'h0;
        avs_be = 4'h0;
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rd(OFF_ABORT_STATUS, 32'h0);
        rd(OFF_ABORT_ADDRESS, 32'h0);
        rd(8'h40, 32'h0);
        for (int i = 0; i < 11; i++) begin
            a = ta[i] | ($urandom & 32'h000f_fff0);
            w = i[0] && !tf[i];
            xfer(M_CPU, a, w, ts[i], tf[i], tu[i] | tm[i]);
            if (tu[i] | tm[i]) begin
                rd(OFF_ABORT_STATUS, st(tu[i], tm[i], ts[i], tf[i] ?
                    TYPE_FETCH : {1'b0, w}, 3'b100, 3'h0));
                rd(OFF_ABORT_ADDRESS, a);
            end
        end
        foreach (rw[j]) begin
            reg_acc(1'b1, OFF_REMAP, rw[j], rb[j]);
            remap ^= rw[j][0] & rb[j][0];
            a = $urandom & 32'h0000_fffc;
            xfer(M_CPU, a, 1'b0, SIZE_WORD, 1'b0, 1'b0);
            xfer(M_CPU, a | 32'h0020_0000, 1'b0, SIZE_WORD, 1'b0, 1'b0);
        end
        seen.delete();
        fork
            xfer(M_ETH, 32'h0010_0100, 1'b0, SIZE_WORD, 1'b0, 1'b0);
            xfer(M_DMA, 32'h0020_0200, 1'b0, SIZE_HALF, 1'b0, 1'b0);
            xfer(M_CPU, 32'hf000_0300, 1'b0, SIZE_BYTE, 1'b0, 1'b0);
        join
        cmp("order", 34'h24, {28'h0, seen[2][1:0], seen[1][1:0],
            seen[0][1:0]});
        // ethernet and dma carry on regardless of the abort
        xfer(M_ETH, 32'h7000_0010, 1'b0, SIZE_BYTE, 1'b0, 1'b1);
        xfer(M_DMA, 32'h0010_0005, 1'b1, SIZE_HALF, 1'b0, 1'b1);
        rd(OFF_ABORT_STATUS, st(0, 1, SIZE_HALF, TYPE_WRITE, 3'b010,
            3'b001));
        rd(OFF_ABORT_ADDRESS, 32'h0010_0005);
        rd(OFF_ABORT_STATUS, st(0, 1, SIZE_HALF, TYPE_WRITE, 3'b010,
            3'b000));
        // remap on and capture loaded, then reset in mid-run
        reg_acc(1'b1, OFF_REMAP, 32'h1, 4'hf);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        remap = 1'b0;
        @(posedge mclk);
        rd(OFF_ABORT_STATUS, 32'h0);
        rd(OFF_ABORT_ADDRESS, 32'h0);
        xfer(M_CPU, 32'h0000_0040, 1'b0, SIZE_WORD, 1'b0, 1'b0);
        finish_test();
    end
endmodule // bus_memory_controller_tb
